// ---- hw/wdt_pkg.sv ----
/*
 * Package for the watchdog timer unit: register offsets, field layouts,
 * reset values, cycle counts and the bus request carrier.
 * Assumes a 32-bit classic Wishbone slave port and a 250 MHz clk_sys.
 */
package wdt_pkg;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] WDT_OFS_CTRL  = 8'h00;
    localparam logic [7:0] WDT_OFS_CKCFG = 8'h04;
    localparam logic [7:0] WDT_OFS_IRQEN = 8'h08;
    localparam logic [7:0] WDT_OFS_GIE   = 8'h0C;

    // Field positions in the clock configuration and enable registers.
    localparam int WDT_IVL_LO_POS = 6;
    localparam int WDT_IRQEN_POS  = 4;
    localparam int WDT_GIE_POS    = 7;

    // Values after reset.
    localparam logic [1:0] WDT_IVL_RST   = 2'h0;
    localparam logic [3:0] WDT_CTRL_RST  = 4'h0;

    // Default time-out lengths in clocks, one per interval code.
    localparam int unsigned WDT_TO_CLKS_0 = 131072;
    localparam int unsigned WDT_TO_CLKS_1 = 1048576;
    localparam int unsigned WDT_TO_CLKS_2 = 8388608;
    localparam int unsigned WDT_TO_CLKS_3 = 67108864;
    localparam int          WDT_CNT_W     = 26;

    // Grace window after a time-out and length of the reset it issues.
    localparam int          WDT_GRACE_CLKS = 512;
    localparam logic [8:0]  WDT_GRACE_LAST = 9'(WDT_GRACE_CLKS - 1);
    localparam int          WDT_CLK_PER_MC = 4;
    localparam int          WDT_RST_MC     = 2;
    localparam logic [3:0]  WDT_RST_CLKS   = 4'(WDT_RST_MC * WDT_CLK_PER_MC);

    // Control register layout, bit 3 down to bit 0.
    typedef struct packed {
        logic timeout_flag;
        logic reset_cause_flag;
        logic reset_enable_bit;
        logic restart_bit;
    } wdt_ctrl_t;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wdt_wb_req_t;

endpackage

// ---- hw/wdt_top.sv ----
/*
 * Watchdog timer unit: free-running divider, time-out flag, grace window,
 * watchdog system reset and interrupt request, with a Wishbone slave.
 * The interval lengths are parameters; the defaults are the real ones.
 * Assumes ta_open comes from a timed-access unit on clk_sys, and that
 * pwr_fail_rst and sys_rst_in are clk_sys-synchronous reset indications.
 */
// Chosen here: register access over Wishbone and the placing of the registers.
// What this block does
// - Free-running divider, four selectable time-out lengths.
// - Set time-out flag when interval elapses.
// - Reset after further 512 clocks without restart.
// - Reset lasts two machine cycles, sets cause.
// - Interrupt needs flag, own and global enable.
// - Interrupt and reset paths work independently.
// - Restart clears counter; restart bit self-clears.
// - Flag still set with reset, interrupt off.
// - Power-on or power-fail reset disables watchdog.
// - Own reset restarts count, keeps watchdog enabled.
// - Flag cleared by software or any reset.
// - Cause flag sticky; software or power-fail clears.
// - Reset disabled means cause flag untouched.
// - Reset disable leaves counter and flag running.
// - Protected bits need timed-access procedure.
// - Machine cycle is four clocks; reset eight.
`timescale 1ns/1ps
`default_nettype none

module wdt_top
    import wdt_pkg::*;
#(
    parameter int unsigned TO_CLKS_0 = WDT_TO_CLKS_0,
    parameter int unsigned TO_CLKS_1 = WDT_TO_CLKS_1,
    parameter int unsigned TO_CLKS_2 = WDT_TO_CLKS_2,
    parameter int unsigned TO_CLKS_3 = WDT_TO_CLKS_3
) (
    input  wire logic        clk_sys,      // System clock, 250 MHz.
    input  wire logic        rstn,         // Power-on reset, active low.
    input  wire logic        pwr_fail_rst, // Power-fail reset, high.
    input  wire logic        sys_rst_in,   // Other system reset, high.
    input  wire logic        ta_open,      // Timed-access window open.
    input  wire wdt_wb_req_t wb_req,       // Wishbone request.
    output logic             wb_ack,       // Wishbone acknowledge.
    output logic [31:0]      wb_rdat,      // Wishbone read data.
    output logic             wdt_irq,      // Interrupt request, high.
    output logic             wdt_rst_o     // Watchdog system reset, high.
);

    ////////////////////////////////////////////////////////////////////
    // State.
    // Everything below is cleared by rstn, the power-on reset.
    wdt_ctrl_t              ctrl_reg;
    logic [1:0]             ivl_reg;
    logic                   irq_en_reg;
    logic                   gie_reg;
    logic                   run_reg;
    logic [WDT_CNT_W-1:0]   cnt_reg;
    logic                   grace_reg;
    logic [8:0]             grace_cnt_reg;
    logic [3:0]             rst_cnt_reg;
    logic                   rst_out_reg;
    logic                   ack_reg;
    logic [31:0]            rdat_reg;

    ////////////////////////////////////////////////////////////////////
    // Bus decode. A write lands on the edge where ack is sampled high.
    // Only byte lane 0 carries register bits; the upper lanes are ignored
    // so that a 32-bit master can use plain word stores.
    wire bus_req   = wb_req.cyc & wb_req.stb;
    wire wr_take   = bus_req & wb_req.we & ack_reg & wb_req.sel[0];
    wire hit_ctrl  = (wb_req.adr == WDT_OFS_CTRL);
    wire hit_ckcfg = (wb_req.adr == WDT_OFS_CKCFG);
    wire hit_irqen = (wb_req.adr == WDT_OFS_IRQEN);
    wire hit_gie   = (wb_req.adr == WDT_OFS_GIE);
    wire wr_ctrl   = wr_take & hit_ctrl;
    wire wr_prot   = wr_ctrl & ta_open;
    wire [7:0] wd  = wb_req.dat[7:0];

    // Read data mux; unmapped offsets read as zero but still get an ack.
    wire [7:0] rd_mux =
        hit_ctrl  ? {4'h0, ctrl_reg} :
        hit_ckcfg ? {ivl_reg, 6'h00} :
        hit_irqen ? {3'h0, irq_en_reg, 4'h0} :
        hit_gie   ? {gie_reg, 7'h00} : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Interval select and terminal-count detection.
    // The interval lengths are parameters so a bench can shrink them; they
    // must stay powers of two, or the mask test below no longer works.
    // Each mask is the interval minus one: the low bits that must be set.
    localparam logic [WDT_CNT_W-1:0] MASK_0 = WDT_CNT_W'(TO_CLKS_0 - 1);
    localparam logic [WDT_CNT_W-1:0] MASK_1 = WDT_CNT_W'(TO_CLKS_1 - 1);
    localparam logic [WDT_CNT_W-1:0] MASK_2 = WDT_CNT_W'(TO_CLKS_2 - 1);
    localparam logic [WDT_CNT_W-1:0] MASK_3 = WDT_CNT_W'(TO_CLKS_3 - 1);

    // The low bits under the mask all being one means the next increment
    // wraps the selected bit, which is the time-out point.
    wire [WDT_CNT_W-1:0] ivl_mask =
        (ivl_reg == 2'h0) ? MASK_0 :
        (ivl_reg == 2'h1) ? MASK_1 :
        (ivl_reg == 2'h2) ? MASK_2 : MASK_3;
    wire tick = run_reg & ~rst_out_reg
              & ((cnt_reg & ivl_mask) == ivl_mask);
    wire restart_req = wr_prot & wd[0];
    wire grace_end   = grace_reg & (grace_cnt_reg == WDT_GRACE_LAST);
    // A restart in the last grace cycle still saves the system.
    // Software that writes exactly on the last grace clock is forgiven.
    wire fire = grace_end & ctrl_reg.reset_enable_bit
              & ~restart_req;
    // Both external resets are treated alike for the time-out flag.
    wire ext_rst = pwr_fail_rst | sys_rst_in;

    // Counter next value: held at zero while stopped or resetting.
    // Zeroing on the firing edge restarts the count after our own reset.
    wire [WDT_CNT_W-1:0] cnt_next =
        (!run_reg || rst_out_reg || fire || restart_req) ? '0 :
        cnt_reg + 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Control flag next values. Hardware sets beat software clears.
    // Resets beat both, so a time-out in a reset cycle is lost on purpose;
    // software then sees a clean flag once the reset is over.
    wire flag_sw  = wr_prot ? wd[3] : ctrl_reg.timeout_flag;
    wire flag_next = (ext_rst || fire) ? 1'b0 :
                     (tick | flag_sw);
    wire cause_sw = wr_ctrl ? wd[2] : ctrl_reg.reset_cause_flag;
    // The cause flag only moves from the watchdog when reset is enabled.
    wire cause_next = pwr_fail_rst ? 1'b0 :
                      (fire | cause_sw);
    // Only power-fail is handled here; rstn clears every register
    // anyway, so the power-on case needs no term of its own.
    wire en_next = pwr_fail_rst ? 1'b0 :
                   (wr_prot ? wd[1] : ctrl_reg.reset_enable_bit);

    ////////////////////////////////////////////////////////////////////
    // Outputs.
    // The reset output comes straight from a flop so it cannot glitch.
    assign wb_ack    = ack_reg;
    assign wb_rdat   = rdat_reg;
    assign wdt_rst_o = rst_out_reg;
    // Interrupt path ignores the reset enable entirely.
    assign wdt_irq = ctrl_reg.timeout_flag & irq_en_reg & gie_reg;

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack drops the cycle after it.
    // Read data is captured every cycle; it only matters while ack is high.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= bus_req & ~ack_reg;
            rdat_reg <= {24'h00_0000, rd_mux};
        end
    end

    // Software-only configuration, unprotected.
    // These bits hold no safety function, so no unlock is asked for them.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ivl_reg    <= WDT_IVL_RST;
            irq_en_reg <= 1'b0;
            gie_reg    <= 1'b0;
        end else begin
            if (wr_take && hit_ckcfg)
                ivl_reg <= wd[WDT_IVL_LO_POS +: 2];
            if (wr_take && hit_irqen)
                irq_en_reg <= wd[WDT_IRQEN_POS];
            if (wr_take && hit_gie)
                gie_reg <= wd[WDT_GIE_POS];
        end
    end

    // Control bits. The restart bit reads one for a single cycle only.
    // The cause bit stays writable without unlock so boot code can clear it.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= WDT_CTRL_RST;
        end else begin
            ctrl_reg.timeout_flag     <= flag_next;
            ctrl_reg.reset_cause_flag <= cause_next;
            ctrl_reg.reset_enable_bit <= en_next;
            ctrl_reg.restart_bit      <= restart_req & ~ctrl_reg.restart_bit;
        end
    end

    // Divider. Stopped after power-on until the first restart, so that
    // counting always begins from a known state.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            run_reg <= ~pwr_fail_rst & (run_reg | restart_req);
            cnt_reg <= pwr_fail_rst ? '0 : cnt_next;
        end
    end

    // Grace window after a time-out that finds no window open.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            grace_reg     <= 1'b0;
            grace_cnt_reg <= 9'h000;
        end else if (pwr_fail_rst || restart_req || grace_end) begin
            grace_reg     <= 1'b0;
            grace_cnt_reg <= 9'h000;
        end else if (tick && !grace_reg) begin
            // Later time-outs must not stretch an open window, or short
            // intervals would hold the reset off for ever.
            grace_reg     <= 1'b1;
            grace_cnt_reg <= 9'h000;
        end else if (grace_reg) begin
            grace_cnt_reg <= grace_cnt_reg + 9'h001;
        end
    end

    // Watchdog reset pulse, eight clocks long.
    // The count runs down from seven, so the pulse is two machine cycles.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_reg <= 4'h0;
            rst_out_reg <= 1'b0;
        end else if (fire) begin
            rst_cnt_reg <= WDT_RST_CLKS - 4'h1;
            rst_out_reg <= 1'b1;
        end else if (rst_cnt_reg != 4'h0) begin
            rst_cnt_reg <= rst_cnt_reg - 4'h1;
        end else begin
            rst_out_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.
    // All checks run on clk_sys and are idle while rstn is low; they watch
    // internal state so a failure names the register that went wrong.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Bus handshake: one acknowledge per request, then a gap.
    wb_ack_once_a: assert property (
        bus_req && !ack_reg |=> ack_reg ##1 !ack_reg
    ) else $error("ack not a single cycle after request");

    // The interrupt can only appear after a time-out or a register write,
    // so a stray rise points at a broken gate or a glitching enable.
    irq_gate_a: assert property (
        $rose(wdt_irq) |-> $past(tick) || $past(wr_take)
    ) else $error("interrupt rose without time-out or write");

    // A time-out in the firing cycle loses to the watchdog reset.
    flag_set_a: assert property (
        tick && !ext_rst && !fire |=> ctrl_reg.timeout_flag
    ) else $error("time-out flag not set after time-out");

    // Reset timing: grace length, pulse width and the cause flag.
    grace_fire_a: assert property (
        $rose(rst_out_reg) |-> $past(grace_cnt_reg) == WDT_GRACE_LAST
            && $past(ctrl_reg.reset_enable_bit)
    ) else $error("watchdog reset not 512 clocks after time-out");

    rst_len_a: assert property (
        $rose(rst_out_reg) |-> rst_out_reg[*8] ##1 !rst_out_reg
    ) else $error("watchdog reset not eight clocks long");

    cause_set_a: assert property (
        $rose(rst_out_reg) && !$past(pwr_fail_rst)
            |-> ctrl_reg.reset_cause_flag
    ) else $error("cause flag missing at watchdog reset");

    // Restart and unlock behaviour.
    restart_clr_a: assert property (
        restart_req && !pwr_fail_rst |=> cnt_reg == '0
            && ctrl_reg.restart_bit ##1 !ctrl_reg.restart_bit
    ) else $error("restart did not clear counter or self-clear");

    ta_guard_a: assert property (
        wr_ctrl && !ta_open && !pwr_fail_rst
            |=> $stable(ctrl_reg.reset_enable_bit) && !ctrl_reg.restart_bit
    ) else $error("protected bit changed outside unlock window");

    cause_quiet_a: assert property (
        !ctrl_reg.reset_enable_bit && !wr_ctrl
            |=> !$rose(ctrl_reg.reset_cause_flag)
    ) else $error("cause flag set while reset disabled");

    pf_off_a: assert property (
        pwr_fail_rst |=> !run_reg && !ctrl_reg.reset_enable_bit
            && !ctrl_reg.reset_cause_flag
    ) else $error("power-fail did not disable watchdog");

    own_rst_run_a: assert property (
        rst_out_reg && !$past(pwr_fail_rst) |-> run_reg && cnt_reg == '0
    ) else $error("watchdog reset stopped or did not zero counter");

    // Both external resets clear the time-out flag, and so does software.
    flag_rst_a: assert property (
        ext_rst |=> !ctrl_reg.timeout_flag
    ) else $error("time-out flag survived a system reset");

    flag_swclr_a: assert property (
        wr_prot && !wd[3] && !tick && !ext_rst
            |=> !ctrl_reg.timeout_flag
    ) else $error("time-out flag not cleared by software");

    // The cause flag stays put until software or power-fail moves it.
    cause_keep_a: assert property (
        ctrl_reg.reset_cause_flag && !wr_ctrl && !pwr_fail_rst
            |=> ctrl_reg.reset_cause_flag
    ) else $error("cause flag lost without a clear");

    // With reset disabled the grace end must pass quietly, while the
    // divider keeps counting through it.
    fire_gated_a: assert property (
        grace_end && !ctrl_reg.reset_enable_bit |=> !rst_out_reg
    ) else $error("watchdog reset issued while disabled");

    cnt_step_a: assert property (
        run_reg && !rst_out_reg && !fire && !restart_req && !pwr_fail_rst
            |=> cnt_reg == $past(cnt_reg) + 1'b1
    ) else $error("divider skipped or held a count");

    // Grace window: opened by the first time-out, closed by a restart.
    grace_open_a: assert property (
        tick && !grace_reg && !restart_req && !pwr_fail_rst
            |=> grace_reg && grace_cnt_reg == 9'h000
    ) else $error("grace window did not open at time-out");

    restart_save_a: assert property (
        restart_req && !rst_out_reg && !pwr_fail_rst
            |=> !grace_reg && !rst_out_reg
    ) else $error("restart did not cancel the grace window");

    // The reset path fires whatever the interrupt enables say.
    rst_path_a: assert property (
        fire |=> rst_out_reg
    ) else $error("watchdog reset missing after grace end");

    // After power-on or power-fail the divider waits for a restart.
    halt_idle_a: assert property (
        !run_reg && !restart_req |=> !run_reg && cnt_reg == '0
    ) else $error("divider counted before its first restart");

endmodule

`default_nettype wire

// ---- tb/wdt_top_test.sv ----
/*
 * Self-checking bench for the watchdog timer unit, run with short intervals.
 * Assumes wdt_pkg and wdt_top from hw/, one clock and no partner model.
 */
`timescale 1ns/1ps
`default_nettype none

module wdt_top_test
    import wdt_pkg::*;
;
    localparam int unsigned IV [4] = '{16, 32, 64, 128};

    logic        clk_sys      = 1'b0;
    logic        rstn         = 1'b0;
    logic        pwr_fail_rst = 1'b0;
    logic        sys_rst_in   = 1'b0;
    logic        ta_open      = 1'b0;
    wdt_wb_req_t wb_req       = '0;
    logic        wb_ack;
    logic [31:0] wb_rdat;
    logic        wdt_irq;
    logic        wdt_rst_o;
    logic [32:0] exp_q [$];
    logic [32:0] note;
    int          num_errors   = 0;
    int          check_count  = 0;
    int          cyc_n        = 0;
    int          seed         = 63698;
    int          ack_cyc;
    int          n;
    int          t0;

    wdt_top #(.TO_CLKS_0(IV[0]), .TO_CLKS_1(IV[1]), .TO_CLKS_2(IV[2]),
              .TO_CLKS_3(IV[3])) wdt_top_inst (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .pwr_fail_rst (pwr_fail_rst),
        .sys_rst_in   (sys_rst_in),
        .ta_open      (ta_open),
        .wb_req       (wb_req),
        .wb_ack       (wb_ack),
        .wb_rdat      (wb_rdat),
        .wdt_irq      (wdt_irq),
        .wdt_rst_o    (wdt_rst_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle count and the hang limit.
    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n > 12000) begin
            num_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared comparison and closing report.
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One classic Wishbone cycle; random upper data bits must be ignored.
    // The expected read value is queued for the monitor, never checked here.
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [7:0] d, input logic ta,
                      input logic [31:0] exp);
        wb_req  <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                     dat: ($random(seed) & 32'hFFFF_FF00) | 32'(d)};
        ta_open <= ta;
        exp_q.push_back({~we, exp});
        @(posedge clk_sys);
        while (wb_ack !== 1'b1) @(posedge clk_sys);
        ack_cyc = cyc_n;
        wb_req  <= '0;
        ta_open <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Edges from the last acknowledge until the interrupt is seen high.
    task automatic wait_irq;
        while (wdt_irq !== 1'b1) @(posedge clk_sys);
        n = cyc_n - ack_cyc;
    endtask

    // Monitor: every acknowledge retires the oldest note in the queue.
    always @(posedge clk_sys) begin
        if (wb_ack === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[32]) check("read data", wb_rdat, note[31:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; the divider must stay idle until the first restart.
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0000);
        wb(1'b0, WDT_OFS_CKCFG, 8'h00, 1'b0, 32'h0000_0000);
        wb(1'b0, 8'h10, 8'h00, 1'b0, 32'h0000_0000);
        wb(1'b1, WDT_OFS_CTRL, 8'h0B, 1'b0, 32'h0000_0000);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0000);
        wb(1'b1, WDT_OFS_IRQEN, 8'h10, 1'b0, 32'h0000_0000);
        wb(1'b1, WDT_OFS_GIE, 8'h80, 1'b0, 32'h0000_0000);
        repeat (200) @(posedge clk_sys);
        check("idle before restart", wdt_irq, 1'b0);
        // Each interval code, timed from the restart acknowledge.
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, WDT_OFS_CKCFG, 8'(i << 6), 1'b0, 32'h0000_0000);
            wb(1'b1, WDT_OFS_CTRL, 8'h01, 1'b1, 32'h0000_0000);
            wait_irq();
            check("time-out delay", n, IV[i] + 1);
            wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0008);
            wb(1'b1, WDT_OFS_CTRL, 8'h00, 1'b1, 32'h0000_0000);
        end
        // Global enable low masks the request while the flag is set.
        wb(1'b1, WDT_OFS_GIE, 8'h00, 1'b0, 32'h0000_0000);
        repeat (140) @(posedge clk_sys);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0008);
        check("masked request", wdt_irq, 1'b0);
        wb(1'b1, WDT_OFS_GIE, 8'h80, 1'b0, 32'h0000_0000);
        check("unmasked request", wdt_irq, 1'b1);
        // Reset enabled and no restart: grace length and reset width.
        wb(1'b1, WDT_OFS_CKCFG, 8'h00, 1'b0, 32'h0000_0000);
        wb(1'b1, WDT_OFS_CTRL, 8'h03, 1'b1, 32'h0000_0000);
        wait_irq();
        t0 = cyc_n;
        while (wdt_rst_o !== 1'b1) @(posedge clk_sys);
        check("grace length", cyc_n - t0, 512);
        n = 0;
        while (wdt_rst_o === 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        t0 = cyc_n;
        check("reset width", n, 8);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0006);
        wait_irq();
        check("runs after own reset", cyc_n - t0, IV[0]);
        // A restart inside the grace window keeps the system alive.
        wb(1'b1, WDT_OFS_CTRL, 8'h07, 1'b1, 32'h0000_0000);
        wait_irq();
        check("restart in grace", n, IV[0] + 1);
        // Reset disabled inside the grace window: no reset, cause kept.
        wb(1'b1, WDT_OFS_CTRL, 8'h04, 1'b1, 32'h0000_0000);
        n = 0;
        repeat (600) begin
            @(posedge clk_sys);
            if (wdt_rst_o !== 1'b0) n++;
        end
        check("reset while disabled", n, 0);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_000C);
        // Other system reset clears only the flag; power-fail clears the control bits and stops the divider.
        wb(1'b1, WDT_OFS_CKCFG, 8'hC0, 1'b0, 32'h0000_0000);
        wb(1'b1, WDT_OFS_CTRL, 8'h05, 1'b1, 32'h0000_0000);
        wait_irq();
        sys_rst_in <= 1'b1;
        @(posedge clk_sys);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0004);
        pwr_fail_rst <= 1'b1;
        @(posedge clk_sys);
        pwr_fail_rst <= 1'b0;
        @(posedge clk_sys);
        wb(1'b0, WDT_OFS_CTRL, 8'h00, 1'b0, 32'h0000_0000);
        repeat (300) @(posedge clk_sys);
        check("stopped by power-fail", wdt_irq, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
